//--- hdl/ast_pkg.sv
/*
  Constants shared by the asynchronous serial transceiver: register map,
  field positions, reset values, frame formats, oversampling counts, states.
  Assumes a 32-bit AXI4-Lite register bus and a single 25 MHz clock.
*/
package ast_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0c;
  localparam logic [7:0] ADDR_BAUD   = 8'h10;
  localparam logic [7:0] ADDR_IFLAG  = 8'h14;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int MODE_EN_BIT  = 15;
  localparam int MODE_FMT_LO  = 1;
  localparam int MODE_STOP    = 0;
  localparam int STA_TXISEL   = 15;
  localparam int STA_TXBRK    = 11;
  localparam int STA_TXEN     = 10;
  localparam int STA_TXBF     = 9;
  localparam int STA_TXEMPTY  = 8;
  localparam int STA_RXISEL   = 6;
  localparam int STA_ADDR_DETECT_ENABLE    = 5;
  localparam int STA_RXIDLE   = 4;
  localparam int STA_PARITY_ERR     = 3;
  localparam int STA_FRAMING_ERR     = 2;
  localparam int STA_OVERRUN_ERR     = 1;
  localparam int STA_RXDA     = 0;
  localparam int IFL_TX       = 0;
  localparam int IFL_RX       = 1;

  // ------------------------------------------------------------------
  // reset values, formats, counts
  // ------------------------------------------------------------------
  localparam logic [1:0]  FMT_RST     = 2'h0;
  localparam logic        STOP_RST    = 1'b0;
  localparam logic [15:0] BAUD_RST    = 16'h0000;
  localparam logic [1:0]  FMT_8N      = 2'h0;
  localparam logic [1:0]  FMT_8E      = 2'h1;
  localparam logic [1:0]  FMT_8O      = 2'h2;
  localparam logic [1:0]  FMT_9N      = 2'h3;
  localparam logic [2:0]  FIFO_DEPTH  = 3'h4;
  localparam logic [2:0]  RX_LVL3     = 3'h3;
  localparam logic [3:0]  OVS_LAST    = 4'hf;
  localparam logic [3:0]  OVS_MID     = 4'h7;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    AST_TX_IDLE  = 2'h0,
    AST_TX_WAIT  = 2'h1,
    AST_TX_SHIFT = 2'h3
  } ast_tx_st_t;

  typedef enum logic [1:0] {
    AST_RX_IDLE  = 2'h0,
    AST_RX_START = 2'h1,
    AST_RX_BITS  = 2'h3,
    AST_RX_HOLD  = 2'h2
  } ast_rx_st_t;

endpackage

//--- hdl/ast_uart.sv
/*
  Asynchronous serial transceiver with four-word transmit and receive
  FIFOs, break, selectable interrupt conditions and a 16-bit baud divider,
  reached over AXI4-Lite. Assumes serial_rx is asynchronous to aclk and that
  the pad logic honours serial_tx_oe_n.
*/
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns

// Overview of operation
// - when enabled, tx pin is driven output, rx is input, tx idles high
// - disabling empties FIFOs, resets baud counter and status flags, keeps config
// - disabling mid-frame aborts everything; re-enable resumes same config
// - frame is 8 bits with none/even/odd parity or 9 bits; one or two stops
// - reset default is 8 data bits, no parity, one stop bit
// - word written with free shifter loads at once, starts on next baud tick
// - enabling transmit after a write starts at once from a cleared baud clock when both shifters are idle
// - transmit FIFO is 9 bits by 4; full flag shows when it is full
// - a write to a full transmit FIFO is dropped, contents untouched
// - both FIFOs clear on reset and on disable, keep contents otherwise
// - tx flag on each FIFO-to-shifter move, or only when it empties FIFO
// - break forces tx low over all transmit activity
// - a break never raises the transmit flag
// - overrun stays set until software clears it; software checks it first
// - each data read of a non-empty receive FIFO pops it and updates parity/framing flags
// - receive FIFO holds 4 words; data-available shows it is non-empty
// - reading an empty receive FIFO returns the old value without popping
// - rx flag on every shifter-to-FIFO move when select is 00 or 01
// - select 10 fires at 3 words after a move, 11 fires when FIFO fills
// - bit rate is clock divided by sixteen times divider plus one
module ast_uart
  import ast_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        serial_rx,
  output logic             serial_tx,
  output logic             serial_tx_oe_n
);

  typedef struct packed {
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic             aw_got;
    logic             w_got;
    logic [7:0]       aw_addr;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             en;
    logic [1:0]       fmt;
    logic             stopb;
    logic [15:0]      brg;
    logic             tx_int_sel;
    logic             tx_break;
    logic             tx_en;
    logic [1:0]       rx_int_sel;
    logic             addr_det;
    logic             overrun_err;
    logic             tx_int_flag;
    logic             rx_int_flag;
    logic [15:0]      baud_cnt;
    logic [3:0][8:0]  tx_fifo;
    logic [2:0]       tx_cnt;
    ast_tx_st_t       tx_st;
    logic [12:0]      tx_sh;
    logic [3:0]       tx_left;
    logic [3:0]       tx_sub;
    logic             ser_tx;
    logic             ser_oe_n;
    logic [2:0]       rx_sync;
    logic             rx_lvl;
    ast_rx_st_t       rx_st;
    logic [3:0]       rx_sub;
    logic [3:0]       rx_idx;
    logic [11:0]      rx_sh;
    logic [3:0][10:0] rx_fifo;
    logic [2:0]       rx_cnt;
    logic [10:0]      rx_hold;
    logic             rx_idle;
  } ast_state_t;

  ast_state_t s;
  ast_state_t n;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // bits after the start bit: data, optional parity, stop bits
  function automatic logic [3:0] frame_bits(input logic [1:0] fmt, input logic stopb);
    logic [3:0] nb;
    nb = (fmt == FMT_9N) ? 4'h9 : 4'h8;
    if (fmt == FMT_8E || fmt == FMT_8O) begin
      nb = nb + 4'h1;
    end
    frame_bits = nb + (stopb ? 4'h2 : 4'h1);
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] fmt);
    par_bit = (^d) ^ (fmt == FMT_8O);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] st);
    merge16 = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic ast_state_t rst_state();
    ast_state_t r;
    r          = '0;
    r.fmt      = FMT_RST;
    r.stopb    = STOP_RST;
    r.brg      = BAUD_RST;
    r.awready  = 1'b1;
    r.wready   = 1'b1;
    r.arready  = 1'b1;
    r.ser_tx   = 1'b1;
    r.ser_oe_n = 1'b1;
    r.rx_sync  = 3'h7;
    r.rx_lvl   = 1'b1;
    r.rx_idle  = 1'b1;
    r.tx_st    = AST_TX_IDLE;
    r.rx_st    = AST_RX_IDLE;
    rst_state  = r;
  endfunction

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic        tick;
    logic        tx_evt;
    logic        rx_evt;
    logic        do_wr;
    logic        do_rd;
    logic [15:0] st16;
    logic [15:0] md16;
    logic [10:0] top;
    logic [11:0] sh;
    logic [3:0]  nb;
    logic [8:0]  word;
    logic        framing_err;
    logic        parity_err;
    n      = s;
    tx_evt = 1'b0;
    rx_evt = 1'b0;
    st16   = '0;
    md16   = '0;
    sh     = '0;
    word   = '0;
    framing_err   = 1'b0;
    parity_err   = 1'b0;
    do_wr  = 1'b0;
    do_rd  = 1'b0;
    nb     = frame_bits(s.fmt, s.stopb);
    top    = (s.rx_cnt != 3'h0) ? s.rx_fifo[0] : s.rx_hold;
    tick   = s.en && (s.baud_cnt == 16'h0000);

    // ----------------------------------------------------------------
    // rx pin synchroniser: second and third stage must agree
    // ----------------------------------------------------------------
    n.rx_sync = {s.rx_sync[1:0], serial_rx};
    if (s.rx_sync[1] == s.rx_sync[2]) begin
      n.rx_lvl = s.rx_sync[2];
    end

    // ----------------------------------------------------------------
    // baud divider: one tick per divider+1 clocks, sixteen per bit
    // ----------------------------------------------------------------
    if (tick) begin
      n.baud_cnt = s.brg;
    end else if (s.en) begin
      n.baud_cnt = s.baud_cnt - 16'h0001;
    end

    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    unique case (s.tx_st)
      AST_TX_IDLE: begin
        // holding the load off during break keeps break silent on the flag
        if (s.en && s.tx_en && !s.tx_break && s.tx_cnt != 3'h0) begin
          n.tx_sh = '1;
          n.tx_sh[0] = 1'b0;
          n.tx_sh[8:1] = s.tx_fifo[0][7:0];
          if (s.fmt == FMT_9N) begin
            n.tx_sh[9] = s.tx_fifo[0][8];
          end else if (s.fmt != FMT_8N) begin
            n.tx_sh[9] = par_bit(s.tx_fifo[0][7:0], s.fmt);
          end
          n.tx_left = nb + 4'h1;
          n.tx_fifo = {9'h000, s.tx_fifo[3:1]};
          n.tx_cnt = s.tx_cnt - 3'h1;
          n.tx_st = AST_TX_WAIT;
          tx_evt = 1'b1;
        end
      end
      AST_TX_WAIT: begin
        if (tick) begin
          n.tx_sub = 4'h0;
          n.tx_st = AST_TX_SHIFT;
        end
      end
      AST_TX_SHIFT: begin
        if (tick) begin
          n.tx_sub = s.tx_sub + 4'h1;
          if (s.tx_sub == OVS_LAST) begin
            n.tx_sh = {1'b1, s.tx_sh[12:1]};
            n.tx_left = s.tx_left - 4'h1;
            if (s.tx_left == 4'h1) begin
              n.tx_st = AST_TX_IDLE;
            end
          end
        end
      end
    endcase
    n.ser_oe_n = !s.en;
    if (!s.en) begin
      n.ser_tx = 1'b1;
    end else if (s.tx_break) begin
      n.ser_tx = 1'b0;
    end else if (n.tx_st == AST_TX_SHIFT) begin
      n.ser_tx = n.tx_sh[0];
    end else begin
      n.ser_tx = 1'b1;
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    if (s.awready && awvalid) begin
      n.aw_got = 1'b1;
      n.aw_addr = awaddr;
    end
    if (s.wready && wvalid) begin
      n.w_got = 1'b1;
      n.w_data = wdata;
      n.w_strb = wstrb;
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    do_wr = s.aw_got && s.w_got && !s.bvalid;
    if (do_wr) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      unique case (s.aw_addr)
        ADDR_MODE: begin
          md16 = merge16({s.en, 12'h000, s.fmt, s.stopb}, s.w_data, s.w_strb);
          n.en = md16[MODE_EN_BIT];
          n.fmt = md16[MODE_FMT_LO +: 2];
          n.stopb = md16[MODE_STOP];
          if (s.en && !n.en) begin
            n.tx_en = 1'b0;
            n.tx_break = 1'b0;
          end
        end
        ADDR_STATUS: begin
          st16 = merge16({s.tx_int_sel, 3'h0, s.tx_break, s.tx_en, 2'h0,
                          s.rx_int_sel, s.addr_det, 3'h0, s.overrun_err, 1'b0},
                         s.w_data, s.w_strb);
          n.tx_int_sel = st16[STA_TXISEL];
          n.rx_int_sel = st16[STA_RXISEL +: 2];
          n.addr_det = st16[STA_ADDR_DETECT_ENABLE];
          if (s.en) begin
            n.tx_break = st16[STA_TXBRK];
            n.tx_en = st16[STA_TXEN];
          end
          if (!st16[STA_OVERRUN_ERR]) begin
            n.overrun_err = 1'b0;
          end
          // fresh transmit enable with both shifters idle restarts the divider so a queued word leaves at once
          if (n.tx_en && !s.tx_en && s.tx_st == AST_TX_IDLE && s.rx_st == AST_RX_IDLE) begin
            n.baud_cnt = 16'h0000;
          end
        end
        ADDR_TXDATA: begin
          if (s.en && s.w_strb[0] && n.tx_cnt != FIFO_DEPTH) begin
            n.tx_fifo[n.tx_cnt[1:0]] = {s.w_strb[1] & s.w_data[8], s.w_data[7:0]};
            n.tx_cnt = n.tx_cnt + 3'h1;
          end
        end
        ADDR_BAUD: begin
          n.brg = merge16(s.brg, s.w_data, s.w_strb);
        end
        ADDR_IFLAG: begin
          if (s.w_strb[0]) begin
            n.tx_int_flag = s.tx_int_flag & !s.w_data[IFL_TX];
            n.rx_int_flag = s.rx_int_flag & !s.w_data[IFL_RX];
          end
        end
        ADDR_RXDATA: begin
        end
        default: begin
          n.bresp = RESP_SLVERR;
        end
      endcase
    end

    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    do_rd = s.arready && arvalid;
    if (do_rd) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h00000000;
      unique case (araddr)
        ADDR_MODE: begin
          n.rdata[15:0] = {s.en, 12'h000, s.fmt, s.stopb};
        end
        ADDR_STATUS: begin
          n.rdata[15:0] = {s.tx_int_sel, 3'h0, s.tx_break, s.tx_en,
                           s.tx_cnt == FIFO_DEPTH, s.tx_st == AST_TX_IDLE,
                           s.rx_int_sel, s.addr_det, s.rx_idle,
                           s.rx_cnt != 3'h0 && s.rx_fifo[0][9],
                           s.rx_cnt != 3'h0 && s.rx_fifo[0][10],
                           s.overrun_err, s.rx_cnt != 3'h0};
        end
        ADDR_TXDATA: begin
        end
        ADDR_RXDATA: begin
          n.rdata[8:0] = top[8:0];
          if (s.rx_cnt != 3'h0) begin
            n.rx_hold = s.rx_fifo[0];
            n.rx_fifo = {11'h000, s.rx_fifo[3:1]};
            n.rx_cnt = s.rx_cnt - 3'h1;
          end
        end
        ADDR_BAUD: begin
          n.rdata[15:0] = s.brg;
        end
        ADDR_IFLAG: begin
          n.rdata[IFL_TX] = s.tx_int_flag;
          n.rdata[IFL_RX] = s.rx_int_flag;
        end
        default: begin
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    n.arready = !n.rvalid;

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    if (tick) begin
      unique case (s.rx_st)
        AST_RX_IDLE: begin
          // after an overrun the shifter keeps its word and takes nothing new
          if (!s.rx_lvl && !s.overrun_err) begin
            n.rx_st = AST_RX_START;
            n.rx_sub = 4'h0;
            n.rx_idle = 1'b0;
          end
        end
        AST_RX_START: begin
          n.rx_sub = s.rx_sub + 4'h1;
          if (s.rx_sub == OVS_MID) begin
            n.rx_sub = 4'h0;
            n.rx_idx = 4'h0;
            if (s.rx_lvl) begin
              n.rx_st = AST_RX_IDLE;
              n.rx_idle = 1'b1;
            end else begin
              n.rx_st = AST_RX_BITS;
            end
          end
        end
        AST_RX_BITS: begin
          n.rx_sub = s.rx_sub + 4'h1;
          if (s.rx_sub == OVS_LAST) begin
            sh = s.rx_sh;
            sh[s.rx_idx] = s.rx_lvl;
            n.rx_sh = sh;
            n.rx_idx = s.rx_idx + 4'h1;
            if (s.rx_idx == nb - 4'h1) begin
              word = {(s.fmt == FMT_9N) & sh[8], sh[7:0]};
              if (s.fmt == FMT_9N) begin
                framing_err = !sh[9] || (s.stopb && !sh[10]);
              end else if (s.fmt == FMT_8N) begin
                framing_err = !sh[8] || (s.stopb && !sh[9]);
              end else begin
                parity_err = sh[8] != par_bit(sh[7:0], s.fmt);
                framing_err = !sh[9] || (s.stopb && !sh[10]);
              end
              n.rx_idle = 1'b1;
              n.rx_st = framing_err ? AST_RX_HOLD : AST_RX_IDLE;
              if (n.rx_cnt == FIFO_DEPTH) begin
                n.overrun_err = 1'b1;
              end else begin
                n.rx_fifo[n.rx_cnt[1:0]] = {framing_err, parity_err, word};
                n.rx_cnt = n.rx_cnt + 3'h1;
                rx_evt = 1'b1;
              end
            end
          end
        end
        AST_RX_HOLD: begin
          // a long break must end before the next start edge counts
          if (s.rx_lvl) begin
            n.rx_st = AST_RX_IDLE;
          end
        end
      endcase
    end

    // ----------------------------------------------------------------
    // event flags: a set in the clearing cycle wins
    // ----------------------------------------------------------------
    // a word written in the same cycle keeps the FIFO from being empty
    if (tx_evt && (!s.tx_int_sel || n.tx_cnt == 3'h0)) begin
      n.tx_int_flag = 1'b1;
    end
    if (rx_evt) begin
      if (!s.rx_int_sel[1]) begin
        n.rx_int_flag = 1'b1;
      end else if (!s.rx_int_sel[0] && n.rx_cnt == RX_LVL3) begin
        n.rx_int_flag = 1'b1;
      end else if (s.rx_int_sel[0] && n.rx_cnt == FIFO_DEPTH) begin
        n.rx_int_flag = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // disabled: abort frames, empty FIFOs, clear divider; config kept
    // ----------------------------------------------------------------
    if (!n.en) begin
      n.tx_cnt = 3'h0;
      n.rx_cnt = 3'h0;
      n.tx_st = AST_TX_IDLE;
      n.rx_st = AST_RX_IDLE;
      n.rx_idle = 1'b1;
      n.overrun_err = 1'b0;
      n.baud_cnt = 16'h0000;
    end
  end

  // ------------------------------------------------------------------
  // state register; FIFOs clear only here and on disable
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= rst_state();
    end else begin
      s <= n;
    end
  end

  assign awready        = s.awready;
  assign wready         = s.wready;
  assign bvalid         = s.bvalid;
  assign bresp          = s.bresp;
  assign arready        = s.arready;
  assign rvalid         = s.rvalid;
  assign rresp          = s.rresp;
  assign rdata          = s.rdata;
  assign serial_tx      = s.ser_tx;
  assign serial_tx_oe_n = s.ser_oe_n;

endmodule

//--- bench/ast_uart_properties.sv
/* port checker for ast_uart
   assumes one clock domain and divider 0 in the bench */
`timescale 1ns/1ns
module ast_uart_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        serial_tx,
  input wire logic        serial_tx_oe_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rd_answer: assert property (arvalid && arready |=> rvalid) else $error("read unanswered");
  a_rd_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_rd_busy: assert property (rvalid |-> !arready) else $error("read taken while busy");
  a_wr_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write unanswered");
  a_wr_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_wr_busy: assert property (bvalid |-> !awready && !wready) else $error("write taken busy");
  a_idle_high: assert property (serial_tx_oe_n && $past(serial_tx_oe_n) |-> serial_tx)
    else $error("line low while disabled");
  // a low cell lasts at least half a bit even at the fastest divider
  a_bit_min: assert property ($fell(serial_tx) |=> (!serial_tx || serial_tx_oe_n) [*8])
    else $error("low cell too short");
  c_slverr: cover property (bvalid && bresp == 2'h2);
  c_frame: cover property ($fell(serial_tx));
  c_read: cover property (rvalid && rready);
endmodule
bind ast_uart ast_uart_props i_props (.*);

//--- bench/ast_peer.sv
/* remote serial device on the two line pins
   assumes 16 clocks per bit, no pull on the lines */
`timescale 1ns/1ns
module ast_peer (
  input  wire logic aclk,
  input  wire logic line_in,
  output logic      line_out
);
  initial line_out = 1'b1;
  // 8N1 frame, lsb first; gap idle cycles model a slow sender
  task automatic send(input logic [7:0] v, input int gap);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++) repeat (16) @(posedge aclk) line_out <= f[i];
    repeat (gap) @(posedge aclk);
  endtask
  // samples n cells after the start bit, each at its centre
  task automatic get(input int n, output logic [10:0] v);
    v = '0;
    @(negedge line_in);
    repeat (8) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      repeat (16) @(posedge aclk);
      v[i] = line_in;
    end
  endtask
endmodule

//--- bench/test_ast_uart.sv
/* self-checking bench for ast_uart over AXI4-Lite with a serial peer
   assumes divider 0 after reset, so a bit lasts 16 clocks */
`timescale 1ns/1ns
module test_ast_uart
  import ast_pkg::*;
;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic        serial_rx, serial_tx, oe_n;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [7:0]  q [6];
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0]  bresp, rresp;
  logic [10:0] got;
  int          n_errors = 0, compares = 0, cyc = 0;
  always #20 aclk = ~aclk;
  ast_uart i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .serial_rx(serial_rx), .serial_tx(serial_tx), .serial_tx_oe_n(oe_n));
  ast_peer i_peer (.aclk(aclk), .line_in(serial_tx), .line_out(serial_rx));
  task automatic wrap_up;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    awaddr  <= a;
    wdata   <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      bready <= bvalid;
    end while (1);
    bready <= 1'b0;
    chk({30'h0, bresp},
        {30'h0, ((a > ADDR_IFLAG || a[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY)});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      rready <= rvalid;
    end while (1);
    rready <= 1'b0;
    if (er == RESP_OKAY) chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  function automatic logic [10:0] frm(logic [8:0] v, logic [1:0] f);
    case (f)
      FMT_8N:  return {3'b111, v[7:0]};
      FMT_8E:  return {2'b11, ^v[7:0], v[7:0]};
      FMT_8O:  return {2'b11, ~^v[7:0], v[7:0]};
      default: return {2'b11, v};
    endcase
  endfunction
  initial begin
    d = $urandom(99293);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wr(8'h18, 16'hffff);
    rd(ADDR_MODE, 32'h0, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0110, RESP_OKAY);
    rd(8'h18, 32'h0, RESP_SLVERR);
    wr(ADDR_BAUD, d[15:0]);
    rd(ADDR_BAUD, {16'h0, d[15:0]}, RESP_OKAY);
    wr(ADDR_BAUD, 16'h0000);
    $display("reset test done");
    wr(ADDR_MODE, 16'h8000);
    wr(ADDR_STATUS, 16'h0400);
    for (int f = 0; f < 4; f++) begin
      d = $urandom;
      wr(ADDR_MODE, {1'b1, 12'h0, f[1:0], d[31]});
      d = d & (f == 3 ? 32'h1ff : 32'hff);
      fork
        i_peer.get(11, got);
        wr(ADDR_TXDATA, d[15:0]);
      join
      chk({21'h0, got}, {21'h0, frm(d[8:0], f[1:0])});
      repeat (40) @(posedge aclk);
    end
    $display("format test done");
    wr(ADDR_MODE, 16'h8000);
    wr(ADDR_IFLAG, 16'h0003);
    fork
      for (int i = 0; i < 5; i++) begin
        i_peer.get(9, got);
        chk({23'h0, got[8:0]}, {23'h0, 1'b1, q[i]});
      end
      begin
        for (int i = 0; i < 6; i++) begin
          q[i] = 8'($urandom);
          wr(ADDR_TXDATA, {8'h00, q[i]});
        end
        rd(ADDR_STATUS, 32'h0610, RESP_OKAY);
      end
    join
    repeat (40) @(posedge aclk);
    rd(ADDR_STATUS, 32'h0510, RESP_OKAY);
    rd(ADDR_IFLAG, 32'h1, RESP_OKAY);
    $display("fifo test done");
    wr(ADDR_IFLAG, 16'h0003);
    wr(ADDR_STATUS, 16'h0c00);
    repeat (2) @(posedge aclk);
    chk({31'h0, serial_tx}, 32'h0);
    repeat (224) @(posedge aclk);
    wr(ADDR_STATUS, 16'h0400);
    repeat (32) @(posedge aclk);
    chk({31'h0, serial_tx}, 32'h1);
    rd(ADDR_IFLAG, 32'h0, RESP_OKAY);
    $display("break test done");
    wr(ADDR_STATUS, 16'h04c0);
    for (int i = 0; i < 4; i++) begin
      q[i] = 8'($urandom);
      i_peer.send(q[i], $urandom_range(0, 40));
    end
    repeat (8) @(posedge aclk);
    rd(ADDR_IFLAG, 32'h2, RESP_OKAY);
    rd(ADDR_STATUS, 32'h05d1, RESP_OKAY);
    for (int i = 0; i < 4; i++) rd(ADDR_RXDATA, {24'h0, q[i]}, RESP_OKAY);
    rd(ADDR_RXDATA, {24'h0, q[3]}, RESP_OKAY);
    rd(ADDR_STATUS, 32'h05d0, RESP_OKAY);
    chk({31'h0, oe_n}, 32'h0);
    $display("receive test done");
    wr(ADDR_IFLAG, 16'h0003);
    wr(ADDR_STATUS, 16'h0480);
    for (int i = 0; i < 2; i++) i_peer.send(8'($urandom), 0);
    repeat (8) @(posedge aclk);
    rd(ADDR_IFLAG, 32'h0, RESP_OKAY);
    for (int i = 0; i < 3; i++) i_peer.send(8'($urandom), 0);
    repeat (8) @(posedge aclk);
    rd(ADDR_IFLAG, 32'h2, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0593, RESP_OKAY);
    wr(ADDR_STATUS, 16'h0480);
    rd(ADDR_STATUS, 32'h0591, RESP_OKAY);
    $display("overrun test done");
    wr(ADDR_STATUS, 16'h0080);
    wr(ADDR_TXDATA, 16'h0055);
    wr(ADDR_TXDATA, 16'h00aa);
    wr(ADDR_IFLAG, 16'h0003);
    wr(ADDR_STATUS, 16'h8480);
    repeat (2) @(posedge aclk);
    chk({31'h0, serial_tx}, 32'h0);
    repeat (40) @(posedge aclk);
    rd(ADDR_IFLAG, 32'h0, RESP_OKAY);
    wr(ADDR_MODE, 16'h0000);
    chk({30'h0, oe_n, serial_tx}, 32'h3);
    rd(ADDR_STATUS, 32'h8190, RESP_OKAY);
    rd(ADDR_IFLAG, 32'h0, RESP_OKAY);
    $display("disable test done");
    wrap_up();
  end
endmodule
